// >>> logic/completion_fifo.sv
`include "fdc_regs.svh"
module completion_fifo #(
	parameter int DEPTH = `FDC_CQ_DEPTH
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic [1:0] alloc_n_i,
	input wire logic [1:0] alloc_excp_i,
	input wire logic [DEPTH-1:0] finish_i,
	output logic [2:0] free_o,
	output logic [2:0] head_o,
	output logic [2:0] tail_o,
	output logic [1:0] retire_n_o,
	output logic excp_o
);
	logic [DEPTH-1:0] valid_q;
	logic [DEPTH-1:0] done_q;
	logic [DEPTH-1:0] excp_q;
	logic [2:0] head_q;
	logic [2:0] tail_q;
	logic [2:0] cnt_q;
	logic [2:0] h1;
	logic [2:0] t1;
	logic r0;
	logic r1;
	logic [1:0] rn;
	initial
	begin
		if (DEPTH != 6)
			$error("completion fifo depth must be six");
	end
	function automatic logic [2:0] inc(input logic [2:0] p);
		inc = (p == 3'(DEPTH - 1)) ? 3'h0 : p + 3'h1;
	endfunction
	assign h1 = inc(head_q);
	assign t1 = inc(tail_q);
	// Oldest must be done first; an exception is taken only from the oldest
	assign r0 = valid_q[head_q] && done_q[head_q] && !excp_q[head_q]; // RQ10 RQ22
	assign r1 = r0 && valid_q[h1] && done_q[h1] && !excp_q[h1]; // RQ11 RQ20
	assign rn = {1'b0, r0} + {1'b0, r1};
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			valid_q <= '0; // RQ26
			done_q <= '0;
			excp_q <= '0;
			head_q <= 3'h0;
			tail_q <= 3'h0;
			cnt_q <= 3'h0;
		end
		else
		begin
			for (int i = 0; i < DEPTH; i++)
				if (finish_i[i] && valid_q[i])
					done_q[i] <= 1'b1;
			if (r0)
				valid_q[head_q] <= 1'b0;
			if (r1)
				valid_q[h1] <= 1'b0;
			if (alloc_n_i != 2'h0)
			begin
				valid_q[tail_q] <= 1'b1;
				done_q[tail_q] <= 1'b0;
				excp_q[tail_q] <= alloc_excp_i[0];
			end
			if (alloc_n_i == 2'h2)
			begin
				valid_q[t1] <= 1'b1;
				done_q[t1] <= 1'b0;
				excp_q[t1] <= alloc_excp_i[1];
			end
			head_q <= r1 ? inc(h1) : (r0 ? h1 : head_q);
			tail_q <= (alloc_n_i == 2'h2) ? inc(t1) :
				((alloc_n_i == 2'h1) ? t1 : tail_q);
			cnt_q <= cnt_q + {1'b0, alloc_n_i} - {1'b0, rn}; // RQ18
		end
	end
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			free_o <= 3'(DEPTH);
			retire_n_o <= 2'h0;
			excp_o <= 1'b0;
		end
		else
		begin
			free_o <= 3'(DEPTH) - (cnt_q + {1'b0, alloc_n_i} - {1'b0, rn});
			retire_n_o <= rn;
			excp_o <= valid_q[head_q] && done_q[head_q] && excp_q[head_q]; // RQ21
		end
	end
	assign head_o = head_q;
	assign tail_o = tail_q;
endmodule

// >>> logic/fdc_pkg.sv
`include "fdc_regs.svh"
package fdc_pkg;
	typedef enum logic [2:0]
	{
		U_INTA = 3'h0,
		U_INTB = 3'h1,
		U_FLT = 3'h2,
		U_SYS = 3'h3,
		U_LS = 3'h4,
		U_BR = 3'h5
	} unit_t;
	typedef struct packed
	{
		logic [31:0] pc;
		unit_t unit;
		logic branch_taken;
		logic updates_lr_ctr;
		logic gpr_dst;
		logic fpr_dst;
		logic cr_dst;
		logic dep_wait;
		logic [2:0] dep_tag;
		logic excp;
		logic cmpl_serial;
	} instr_t;
	typedef enum logic [1:0]
	{
		F_IDLE = 2'h0,
		F_L2 = 2'h1,
		F_MEM = 2'h2
	} fetch_st_t;
endpackage

// >>> logic/fdc_regs.svh
`ifndef FDC_REGS_SVH
`define FDC_REGS_SVH
`define FDC_IQ_DEPTH 6
`define FDC_FETCH_MAX 4
`define FDC_DISP_MAX 2
`define FDC_CQ_DEPTH 6
`define FDC_RET_MAX 2
`define FDC_GPR_REN 6
`define FDC_FPR_REN 6
`define FDC_L2_CORE_PRE 1
`define FDC_L2_L2CLK 3
`define FDC_L2_CORE_POST 1
`define FDC_L2_LAT (`FDC_L2_CORE_PRE + `FDC_L2_L2CLK + `FDC_L2_CORE_POST)
`define FDC_LSU_RS 2
`define FDC_RESET_PC 32'h0000_0100
`endif

// >>> logic/fetch_dispatch_completion_ctl.sv
// Functional notes
// RQ1 - Cache hit fills queue next cycle
// RQ2 - Cache hits served during pending reload
// RQ3 - Critical doubleword written and forwarded together
// RQ4 - Fetch count equals prior vacancies, max four
// RQ5 - Dispatch needs completion entry, lowest first
// RQ6 - At most two dispatched, resource limited
// RQ7 - Dispatch bounded by prior completion vacancies
// RQ8 - Plain taken branch folded, no entry
// RQ9 - Target cache hit refills next cycle
// RQ10 - Finished instruction waits for older ones
// RQ11 - Retire at most two per cycle
// RQ12 - First memory beat gives two instructions
// RQ13 - L2 fetch takes five core cycles
// RQ14 - One station per unit, two for load/store
// RQ15 - Dependent instruction dispatched into station
// RQ16 - Station starts when rename data arrives
// RQ17 - Same unit pair goes sequentially
// RQ18 - Completion fifo has six entries
// RQ19 - Stall dispatch when completion fifo full
// RQ20 - Commit results in program order
// RQ21 - Exception raised only at oldest entry
// RQ22 - Long instruction at head blocks younger
// RQ23 - Second slot never ahead of first
// RQ24 - Six gpr, six fpr, one cr/lr/ctr renames
// RQ25 - Link/count branch gets completion entry
// RQ26 - Reset empties queues, fetch from reset address
// RQ27 - Miss request held until first beat
module fetch_dispatch_completion_ctl #(
	parameter int IQ_DEPTH = `FDC_IQ_DEPTH,
	parameter int L2_LAT = `FDC_L2_LAT
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic icache_hit_i,
	input wire logic icache_reload_i,
	input wire fdc_pkg::instr_t [3:0] icache_data_i,
	input wire logic btc_hit_i,
	input wire fdc_pkg::instr_t [1:0] btc_data_i,
	input wire logic l2_hit_i,
	input wire logic mem_beat_i,
	input wire fdc_pkg::instr_t [1:0] mem_data_i,
	input wire logic redirect_i,
	input wire logic [31:0] redirect_pc_i,
	input wire logic [5:0] unit_busy_i,
	input wire logic [7:0] rename_ready_i,
	input wire logic [5:0] cq_finish_i,
	output logic [2:0] fetch_req_n_o,
	output logic [31:0] fetch_pc_o,
	output logic next_level_req_o,
	output logic refill_write_o,
	output logic [63:0] refill_data_o,
	output logic [1:0] dispatch_n_o,
	output fdc_pkg::unit_t [1:0] dispatch_unit_o,
	output logic [2:0] cq_alloc_idx_o,
	output logic [5:0] station_start_o,
	output logic [1:0] retire_n_o,
	output logic exception_o
);
	import fdc_pkg::*;
	localparam int IQW = $clog2(IQ_DEPTH + 1);
	instr_t [IQ_DEPTH-1:0] iq_q;
	logic [IQW-1:0] iq_cnt_q;
	logic [2:0] vac_q;
	fetch_st_t fst_q;
	logic [3:0] lat_q;
	logic [31:0] pc_q;
	logic [2:0] cq_free;
	logic [2:0] cq_tail;
	logic [1:0] cq_ret;
	logic cq_excp;
	logic [2:0] cq_free_prev_q;
	logic [1:0] disp_n;
	logic [1:0] alloc_n;
	logic [2:0] gpr_q;
	logic [2:0] fpr_q;
	logic cr_q;
	logic lrctr_q;
	logic [5:0] rs_full_q;
	logic [2:0] rs_tag_q [6];
	logic ls_two_q;
	logic [2:0] in_n;
	instr_t [3:0] in_d;
	logic fold0;
	logic ok0;
	logic ok1;
	logic [5:0] g_used_q;
	logic [5:0] f_used_q;
	logic [2:0] rh_q;
	logic [2:0] rh1;
	logic [2:0] ct1;
	initial
	begin
		if (IQ_DEPTH < 4 || IQ_DEPTH > 7 || L2_LAT < 2 || L2_LAT > 15)
			$error("unsupported queue depth or latency");
	end
	// A taken branch without link/count update is folded out of slot zero
	assign fold0 = (iq_cnt_q != '0) && iq_q[0].unit == U_BR &&
		iq_q[0].branch_taken && !iq_q[0].updates_lr_ctr; // RQ8 RQ25
	function automatic logic can_go(input instr_t x, input logic [1:0] gu,
		input logic [1:0] fu);
		logic r;
		r = 1'b1;
		if (x.unit != U_BR && unit_busy_i[x.unit] && !x.dep_wait)
			r = 1'b0; // RQ6
		if (x.unit == U_LS)
			r = r && !(rs_full_q[U_LS] && ls_two_q); // RQ14
		else if (x.unit != U_BR && x.dep_wait && rs_full_q[x.unit])
			r = 1'b0; // RQ15
		if (x.gpr_dst && {1'b0, gu} >= gpr_q)
			r = 1'b0; // RQ24
		if (x.fpr_dst && {1'b0, fu} >= fpr_q)
			r = 1'b0;
		if (x.cr_dst && !cr_q)
			r = 1'b0;
		if (x.updates_lr_ctr && !lrctr_q)
			r = 1'b0;
		can_go = r;
	endfunction
	assign ok0 = !fold0 && iq_cnt_q != '0 && cq_free_prev_q != 3'h0 &&
		cq_free != 3'h0 && can_go(iq_q[0], 2'h0, 2'h0); // RQ5 RQ7 RQ19
	assign ok1 = ok0 && !iq_q[0].cmpl_serial && iq_cnt_q > IQW'(1) &&
		cq_free_prev_q > 3'h1 && cq_free > 3'h1 &&
		iq_q[1].unit != iq_q[0].unit && // RQ17
		!(iq_q[1].updates_lr_ctr && iq_q[0].updates_lr_ctr) &&
		!(iq_q[1].cr_dst && iq_q[0].cr_dst) &&
		can_go(iq_q[1], {1'b0, iq_q[0].gpr_dst},
			{1'b0, iq_q[0].fpr_dst}); // RQ23 RQ6
	assign disp_n = ok1 ? 2'h2 : (ok0 ? 2'h1 : 2'h0);
	// Shadow of the fifo head, one cycle late like the retire count
	assign rh1 = (rh_q == 3'(`FDC_CQ_DEPTH - 1)) ? 3'h0 : rh_q + 3'h1;
	assign ct1 = (cq_tail == 3'(`FDC_CQ_DEPTH - 1)) ? 3'h0 : cq_tail + 3'h1;
	assign alloc_n = disp_n;
	always_comb
	begin
		in_n = 3'h0;
		in_d = '0;
		if (btc_hit_i && fst_q == F_IDLE)
		begin
			in_n = (vac_q < 3'h2) ? vac_q : 3'h2; // RQ9
			in_d[1:0] = btc_data_i;
		end
		else if (icache_hit_i && fst_q == F_IDLE)
		begin
			in_n = (vac_q > 3'(`FDC_FETCH_MAX)) ? 3'(`FDC_FETCH_MAX) : vac_q; // RQ1 RQ2
			in_d = icache_data_i;
		end
		else if (mem_beat_i && fst_q != F_IDLE)
		begin
			in_n = (vac_q < 3'h2) ? vac_q : 3'h2; // RQ12
			in_d[1:0] = mem_data_i;
		end
	end
	completion_fifo #(.DEPTH(`FDC_CQ_DEPTH)) u_cq (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.alloc_n_i(alloc_n),
		.alloc_excp_i({iq_q[1].excp, iq_q[0].excp}),
		.finish_i(cq_finish_i),
		.free_o(cq_free),
		.head_o(),
		.tail_o(cq_tail),
		.retire_n_o(cq_ret),
		.excp_o(cq_excp)
	);
	// Instruction queue shift and fill
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i || redirect_i)
		begin
			iq_cnt_q <= '0; // RQ26
			iq_q <= '0;
		end
		else
		begin
			logic [IQW-1:0] rem;
			instr_t [IQ_DEPTH-1:0] nq;
			rem = fold0 ? IQW'(1) : IQW'(disp_n);
			nq = '0;
			for (int i = 0; i < IQ_DEPTH; i++)
				if (IQW'(i) + rem < iq_cnt_q)
					nq[i] = iq_q[i + int'(rem)];
			for (int j = 0; j < 4; j++)
				if (3'(j) < in_n && int'(iq_cnt_q - rem) + j < IQ_DEPTH)
					nq[int'(iq_cnt_q - rem) + j] = in_d[j];
			iq_q <= nq;
			iq_cnt_q <= iq_cnt_q - rem + IQW'(in_n);
		end
	end
	// Fetch request sized from last cycle's vacancies
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			vac_q <= 3'(`FDC_FETCH_MAX);
			fetch_req_n_o <= 3'h0;
			pc_q <= `FDC_RESET_PC; // RQ26
			fetch_pc_o <= `FDC_RESET_PC;
		end
		else
		begin
			logic [IQW:0] v;
			v = (IQW+1)'(IQ_DEPTH) - {1'b0, iq_cnt_q};
			vac_q <= (v > (IQW+1)'(4)) ? 3'h4 : 3'(v); // RQ4
			fetch_req_n_o <= (fst_q == F_IDLE) ? vac_q : 3'h0; // RQ4
			if (redirect_i)
				pc_q <= redirect_pc_i;
			else
				pc_q <= pc_q + {27'h0, in_n, 2'h0};
			fetch_pc_o <= redirect_i ? redirect_pc_i : pc_q;
		end
	end
	// Miss sequencing to L2 or memory
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			fst_q <= F_IDLE;
			lat_q <= 4'h0;
			next_level_req_o <= 1'b0;
		end
		else
		begin
			// A redirect abandons the miss so the new stream can fetch
			if (redirect_i)
			begin
				fst_q <= F_IDLE;
				next_level_req_o <= 1'b0;
			end
			else
			unique case (fst_q)
				F_IDLE:
				begin
					if (!icache_hit_i && !btc_hit_i && vac_q != 3'h0 &&
						!icache_reload_i)
					begin
						fst_q <= l2_hit_i ? F_L2 : F_MEM;
						lat_q <= 4'(L2_LAT - 1);
						next_level_req_o <= 1'b1;
					end
				end
				F_L2:
				begin
					lat_q <= lat_q - 4'h1; // RQ13
					if (lat_q == 4'h1)
					begin
						fst_q <= F_IDLE;
						next_level_req_o <= 1'b0;
					end
				end
				F_MEM:
				begin
					if (mem_beat_i)
					begin
						fst_q <= F_IDLE;
						next_level_req_o <= 1'b0; // RQ27
					end
				end
			endcase
		end
	end
	// Refill write and forward share one beat
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			refill_write_o <= 1'b0;
			refill_data_o <= 64'h0;
		end
		else
		begin
			refill_write_o <= mem_beat_i && fst_q == F_MEM; // RQ3
			refill_data_o <= {mem_data_i[1].pc, mem_data_i[0].pc};
		end
	end
	// Rename pools, stations and dispatch outputs
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			gpr_q <= 3'(`FDC_GPR_REN);
			fpr_q <= 3'(`FDC_FPR_REN);
			cr_q <= 1'b1;
			lrctr_q <= 1'b1;
			rs_full_q <= 6'h0; // RQ26
			g_used_q <= 6'h0;
			f_used_q <= 6'h0;
			rh_q <= 3'h0;
			ls_two_q <= 1'b0;
			for (int k = 0; k < 6; k++)
				rs_tag_q[k] <= 3'h0;
			station_start_o <= 6'h0;
			dispatch_n_o <= 2'h0;
			dispatch_unit_o <= '0;
			cq_alloc_idx_o <= 3'h0;
			cq_free_prev_q <= 3'(`FDC_CQ_DEPTH);
			retire_n_o <= 2'h0;
			exception_o <= 1'b0;
		end
		else
		begin
			logic [2:0] gd;
			logic [2:0] fd;
			logic [5:0] st;
			logic [2:0] gr;
			logic [2:0] fr;
			gd = 3'h0;
			fd = 3'h0;
			gr = 3'h0;
			fr = 3'h0;
			// Gpr and fpr renames come back only for the entries that took them
			if (cq_ret != 2'h0)
			begin
				gr = {2'h0, g_used_q[rh_q]};
				fr = {2'h0, f_used_q[rh_q]};
			end
			if (cq_ret == 2'h2)
			begin
				gr = gr + {2'h0, g_used_q[rh1]};
				fr = fr + {2'h0, f_used_q[rh1]};
			end
			rh_q <= (cq_ret == 2'h2) ?
				((rh_q >= 3'h4) ? rh_q - 3'h4 : rh_q + 3'h2) :
				((cq_ret == 2'h1) ? rh1 : rh_q);
			if (disp_n != 2'h0)
			begin
				g_used_q[cq_tail] <= iq_q[0].gpr_dst; // RQ24
				f_used_q[cq_tail] <= iq_q[0].fpr_dst;
			end
			if (disp_n == 2'h2)
			begin
				g_used_q[ct1] <= iq_q[1].gpr_dst;
				f_used_q[ct1] <= iq_q[1].fpr_dst;
			end
			for (int s = 0; s < 2; s++)
				if (2'(s) < disp_n)
				begin
					gd = gd + {2'h0, iq_q[s].gpr_dst};
					fd = fd + {2'h0, iq_q[s].fpr_dst};
				end
			gpr_q <= gpr_q - gd + gr;
			fpr_q <= fpr_q - fd + fr;
			cr_q <= (cq_ret != 2'h0) || (cr_q && !(ok0 && iq_q[0].cr_dst));
			lrctr_q <= (cq_ret != 2'h0) ||
				(lrctr_q && !(ok0 && iq_q[0].updates_lr_ctr));
			st = 6'h0;
			for (int u = 0; u < 6; u++)
				st[u] = rs_full_q[u] && rename_ready_i[rs_tag_q[u]]; // RQ16
			for (int s = 0; s < 2; s++)
				if (2'(s) < disp_n && iq_q[s].dep_wait && iq_q[s].unit != U_BR)
				begin
					if (iq_q[s].unit == U_LS && rs_full_q[U_LS])
						ls_two_q <= 1'b1;
					rs_tag_q[iq_q[s].unit] <= iq_q[s].dep_tag; // RQ15
				end
			for (int u = 0; u < 6; u++)
			begin
				logic put;
				put = 1'b0;
				for (int s = 0; s < 2; s++)
					if (2'(s) < disp_n && iq_q[s].dep_wait &&
						iq_q[s].unit == unit_t'(u))
						put = 1'b1;
				rs_full_q[u] <= put || (rs_full_q[u] && !st[u] ) ||
					(u == int'(U_LS) && ls_two_q && st[u]);
			end
			if (st[U_LS] && ls_two_q)
				ls_two_q <= 1'b0;
			station_start_o <= st;
			dispatch_n_o <= disp_n;
			dispatch_unit_o <= {iq_q[1].unit, iq_q[0].unit};
			cq_alloc_idx_o <= cq_tail; // RQ5
			cq_free_prev_q <= cq_free; // RQ7
			retire_n_o <= cq_ret;
			exception_o <= cq_excp;
		end
	end
	dispatch_two_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		disp_n <= 2'h2 && (disp_n != 2'h0 -> cq_free != 3'h0)) // RQ6
		else $error("dispatch too wide");
	dispatch_prev_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		{1'b0, disp_n} <= cq_free_prev_q) // RQ7
		else $error("dispatch beyond vacancies");
	fold_no_cq_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		fold0 |-> disp_n == 2'h0) // RQ8
		else $error("folded branch took entry");
	fetch_cap_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		fetch_req_n_o <= 3'h4) // RQ4
		else $error("fetch over four");
	fetch_full_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(vac_q == 3'h0 && fst_q == F_IDLE) |=> fetch_req_n_o == 3'h0) // RQ4
		else $error("fetch while full");
	retire_two_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		retire_n_o <= 2'h2) // RQ11
		else $error("retire over two");
	order_slot_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		ok1 |-> ok0) // RQ23
		else $error("second slot ahead");
	same_unit_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		disp_n == 2'h2 |-> iq_q[0].unit != iq_q[1].unit) // RQ17
		else $error("same unit dual dispatch");
	mem_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(fst_q == F_MEM && !mem_beat_i && !redirect_i) |=>
		next_level_req_o) // RQ27
		else $error("miss request dropped");
	l2_lat_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		$rose(fst_q == F_L2) |-> (fst_q == F_L2)[*4] ##1 fst_q == F_IDLE) // RQ13
		else $error("l2 latency wrong");
	dual_c: cover property (@(posedge core_clk_i) disp_n == 2'h2);
	fold_c: cover property (@(posedge core_clk_i) fold0 && btc_hit_i);
	cqfull_c: cover property (@(posedge core_clk_i) cq_free == 3'h0);
	retire_c: cover property (@(posedge core_clk_i) retire_n_o == 2'h2);
endmodule

// >>> verification/exec_partner.sv
// Execution units: finish whatever was allocated, promptly or after a delay
module exec_partner
	import fdc_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic en_i,
	input wire logic slow_i,
	input wire logic redirect_i,
	input wire logic [1:0] dispatch_n_o,
	input wire logic [2:0] cq_alloc_idx_o,
	output logic [5:0] cq_finish_i,
	output logic [5:0] unit_busy_i,
	output logic [7:0] rename_ready_i
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [5:0] pend_q;
	logic [5:0] alloc;
	logic [3:0] wait_q;
	logic [2:0] nxt;
	always_comb
	begin
		nxt = (cq_alloc_idx_o == 3'h5) ? 3'h0 : cq_alloc_idx_o + 3'h1;
		alloc = 6'h00;
		if (dispatch_n_o != 2'h0)
			alloc[cq_alloc_idx_o] = 1'b1;
		if (dispatch_n_o == 2'h2)
			alloc[nxt] = 1'b1;
	end
	// Slow mode also makes units look busy at random, as real ones would
	always @(negedge core_clk_i)
	begin
		unit_busy_i <= slow_i ? 6'($urandom) : 6'h00;
		rename_ready_i <= 8'($urandom);
		cq_finish_i <= 6'h00;
		// Redirect leaves allocated entries in flight; they still finish
		if (!rst_n_i)
		begin
			pend_q <= 6'h00;
			wait_q <= 4'h0;
		end
		else if (en_i && pend_q != 6'h00 && wait_q == 4'h0)
		begin
			cq_finish_i <= pend_q;
			pend_q <= alloc;
			wait_q <= slow_i ? 4'h7 : 4'h0;
		end
		else
		begin
			pend_q <= pend_q | alloc;
			if (wait_q != 4'h0)
				wait_q <= wait_q - 4'h1;
		end
	end
endmodule

// >>> verification/tb_top.sv
`define CHK(a, b, m) begin n_tests++; if ((a) !== (b)) begin failures++; \
	$display("MISMATCH %0t %s", $time, m); end end
module tb_top;
	import fdc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk_i = 0, rst_n_i = 0, hit = 0, l2 = 0, beat = 0, redir = 0;
	logic en = 0, slow = 0, nlr, rw, exc;
	instr_t [3:0] idata;
	instr_t [1:0] mdata;
	logic [31:0] rpc = 0, fpc;
	logic [5:0] fin, busy, sst;
	logic [7:0] rrdy;
	logic [2:0] freq, aidx;
	logic [1:0] dn, rn;
	logic [63:0] rdata;
	unit_t [1:0] du;
	int failures = 0, n_tests = 0, cyc = 0, disp_tot = 0, ret_tot = 0, r0;
	logic [63:0] exp_q[$];
	fetch_dispatch_completion_ctl i_fetch_dispatch_completion_ctl (
		.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .icache_hit_i(hit),
		.icache_reload_i(1'b0), .icache_data_i(idata), .btc_hit_i(1'b0),
		.btc_data_i(mdata), .l2_hit_i(l2), .mem_beat_i(beat),
		.mem_data_i(mdata), .redirect_i(redir), .redirect_pc_i(rpc),
		.unit_busy_i(busy), .rename_ready_i(rrdy), .cq_finish_i(fin),
		.fetch_req_n_o(freq), .fetch_pc_o(fpc), .next_level_req_o(nlr),
		.refill_write_o(rw), .refill_data_o(rdata), .dispatch_n_o(dn),
		.dispatch_unit_o(du), .cq_alloc_idx_o(aidx), .station_start_o(sst),
		.retire_n_o(rn), .exception_o(exc));
	exec_partner i_exec_partner (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.en_i(en), .slow_i(slow), .redirect_i(redir), .dispatch_n_o(dn),
		.cq_alloc_idx_o(aidx), .cq_finish_i(fin), .unit_busy_i(busy),
		.rename_ready_i(rrdy));
	initial
	begin
		forever #50 core_clk_i = ~core_clk_i;
	end
	// Plain instructions only: a shared cr rename would throttle dispatch
	function automatic instr_t mk(logic ex);
		instr_t t;
		t = '0;
		t.pc = $urandom & 32'hFFFF_FFFC;
		t.unit = unit_t'($urandom_range(4));
		t.gpr_dst = 1'($urandom);
		t.fpr_dst = 1'($urandom);
		t.excp = ex;
		return t;
	endfunction
	task automatic fill(logic [3:0] ex);
		for (int k = 0; k < 4; k++)
			idata[k] = mk(ex[k]);
		mdata[0] = mk(1'b0);
		mdata[1] = mk(1'b0);
	endtask
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge core_clk_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			failures++;
			print_verdict();
		end
	end
	// Watcher: running totals, per-cycle bounds and the refill note queue
	always @(posedge core_clk_i)
	begin
		if (rst_n_i)
		begin
			disp_tot += int'(dn);
			ret_tot += int'(rn);
			`CHK(dn != 2'h3, 1'b1, "dispatch over two")
			`CHK(rn != 2'h3, 1'b1, "retire over two")
			`CHK(freq <= 3'h4, 1'b1, "fetch over four")
			if (rw)
			begin
				if (exp_q.size() == 0)
					`CHK(1'b0, 1'b1, "unexpected refill")
				else
					`CHK(rdata, exp_q.pop_front(), "refill data")
			end
		end
	end
	initial
	begin
		r0 = $urandom(32'h0544A69E);
		fill(4'h0);
		repeat (8) @(negedge core_clk_i);
		`CHK(fpc, 32'h0000_0100, "reset pc")
		`CHK({nlr, rw, dn, rn, exc}, 7'h00, "reset outputs")
		$display("test reset done");
		rst_n_i = 1;
		hit = 1;
		for (int k = 0; k < 6 && freq == 3'h0; k++)
			@(negedge core_clk_i);
		`CHK(freq, 3'h4, "first fetch count")
		$display("test fetch done");
		repeat (30)
		begin
			@(negedge core_clk_i);
			fill(4'h0);
		end
		`CHK(disp_tot, 6, "dispatch past full fifo")
		`CHK(ret_tot, 0, "retire without finish")
		$display("test full done");
		hit = 0;
		en = 1;
		slow = 1;
		repeat (150) @(negedge core_clk_i);
		`CHK(ret_tot, disp_tot, "drain")
		$display("test drain done");
		repeat (8)
		begin
			`CHK(nlr, 1'b1, "miss request held")
			@(negedge core_clk_i);
		end
		exp_q.push_back({mdata[1].pc, mdata[0].pc});
		beat = 1;
		@(negedge core_clk_i);
		beat = 0;
		repeat (4) @(negedge core_clk_i);
		`CHK(exp_q.size(), 0, "refill seen")
		$display("test miss done");
		slow = 0;
		repeat (20) @(negedge core_clk_i);
		redir = 1;
		rpc = $urandom & 32'hFFFF_FFFC;
		@(negedge core_clk_i);
		redir = 0;
		fill(4'h2);
		hit = 1;
		r0 = ret_tot;
		@(negedge core_clk_i);
		hit = 0;
		for (int k = 0; k < 60 && exc !== 1'b1; k++)
			@(negedge core_clk_i);
		`CHK(exc, 1'b1, "exception raised")
		`CHK(ret_tot - r0, 1, "older retired first")
		repeat (3) @(negedge core_clk_i);
		`CHK({exc, rn}, 3'h4, "exception head blocks")
		redir = 1;
		l2 = 1;
		@(negedge core_clk_i);
		redir = 0;
		@(negedge core_clk_i);
		$display("test exception done");
		repeat (4)
		begin
			`CHK(nlr, 1'b1, "l2 request held")
			@(negedge core_clk_i);
		end
		`CHK(nlr, 1'b0, "l2 request ends")
		$display("test l2 done");
		print_verdict();
	end
endmodule
